// ### hw/pidr_regs.svh
// Register offsets, field positions, reset values and timing counts of the PID regulator
`ifndef PIDR_REGS_SVH
`define PIDR_REGS_SVH

// Register byte offsets
`define PIDR_CTRL_OFS        12'h000
`define PIDR_MANUAL_OFS      12'h004
`define PIDR_GAIN_OFS        12'h008
`define PIDR_TI_OFS          12'h00c
`define PIDR_TD_OFS          12'h010
`define PIDR_PERIOD_OFS      12'h014
`define PIDR_OUTPUT_OFS      12'h018
`define PIDR_STATUS_OFS      12'h01c

// Control register fields
`define PIDR_CTRL_INV_SP     0
`define PIDR_CTRL_INV_PV     1
`define PIDR_CTRL_INV_RS     2
`define PIDR_CTRL_MANUAL     3
`define PIDR_CTRL_CONN_SP    4
`define PIDR_CTRL_CONN_PV    5
`define PIDR_CTRL_CONN_RS    6
`define PIDR_CTRL_WIDTH      7

// Status register fields
`define PIDR_STAT_WINDUP     0
`define PIDR_STAT_RESET      1
`define PIDR_STAT_BUSY       2

// Normalized values: unsigned Q1.16, 1.0 is 0x10000
`define PIDR_NORM_ONE        17'h10000
`define PIDR_NORM_HALF       17'h08000

// Reset values; gain in units of 1/1024, times in milliseconds
`define PIDR_CTRL_RST        7'h00
`define PIDR_MANUAL_RST      17'h08000
`define PIDR_GAIN_FRAC       10
`define PIDR_GAIN_RST        27'h0000400
`define PIDR_TI_RST          27'h0000064
`define PIDR_TD_RST          27'h000000a
`define PIDR_PERIOD_RST      14'h0001

// Limits
`define PIDR_GAIN_MAX        27'h61a8000
`define PIDR_TIME_MAX        27'h5f5e100
`define PIDR_PERIOD_MIN      14'h0001
`define PIDR_PERIOD_MAX      14'h2710
`define PIDR_SUM_MAX         64'sh0000_0000_3fff_ffff
`define PIDR_SUM_MIN         (-64'sh0000_0000_4000_0000)

// Timing: one millisecond at the 4 ns clock
`define PIDR_CLK_NS          4
`define PIDR_MS_NS           1000000
`define PIDR_CYC_PER_MS      (`PIDR_MS_NS / `PIDR_CLK_NS)
`define PIDR_DIV_STEPS       7'd64

`endif

// ### hw/pidr_pkg.sv
// Types shared by the PID regulator modules
package pidr_pkg;

  // Normalized inputs from other function blocks
  typedef struct packed {
    logic [16:0] norm_setpoint_value;
    logic [16:0] norm_process_value;
    logic [16:0] norm_reset_value;
  } pidr_inputs_type;

  typedef enum logic [1:0] {
    PIDR_IDLE,
    PIDR_DIV_INT,
    PIDR_DIV_DER,
    PIDR_APPLY
  } pidr_state_type;

endpackage

// ### hw/pidr_divider.sv
// Sequential signed-by-unsigned divider, one quotient bit per clock
`include "pidr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module pidr_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [63:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [63:0]      quotient
);
  import pidr_pkg::*;

  logic [32:0] rem;
  logic [63:0] quo;
  logic [6:0]  cnt;
  logic        neg;
  logic [32:0] trial;

  // Next remainder candidate
  assign trial = {rem[31:0], quo[63]};

  ////////////////////////////////////////////////////////////////////////////
  // Restoring division on magnitudes; sign restored at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem      <= 33'h0;
      quo      <= 64'h0;
      cnt      <= 7'h0;
      neg      <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= 64'h0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        neg  <= dividend[63];
        quo  <= dividend[63] ? (~dividend + 64'h1) : dividend;
        rem  <= 33'h0;
        cnt  <= `PIDR_DIV_STEPS;
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, divisor}) begin
          rem <= trial - {1'b0, divisor};
          quo <= {quo[62:0], 1'b1};
        end else begin
          rem <= trial;
          quo <= {quo[62:0], 1'b0};
        end
        cnt <= cnt - 7'h1;
        if (cnt == 7'h1) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          quotient <= neg ? (~{quo[62:0], (trial >= {1'b0, divisor})} + 64'h1)
                          : {quo[62:0], (trial >= {1'b0, divisor})};
        end
      end
    end
  end
endmodule // pidr_divider
`default_nettype wire

// ### hw/pidr_regulator.sv
// PID regulator with APB register slave and timed control cycle
`include "pidr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module pidr_regulator #(
  parameter int unsigned CYC_PER_MS = `PIDR_CYC_PER_MS
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  input  wire pidr_pkg::pidr_inputs_type norm_in,
  output logic [16:0]                   norm_output_value
);
  import pidr_pkg::*;

  // Input select: unconnected reads zero, inversion is 1 - x
  function automatic logic [16:0] norm_pick(input logic [16:0] v,
                                            input logic conn,
                                            input logic inv);
    logic [16:0] lim;
    lim = (v > `PIDR_NORM_ONE) ? `PIDR_NORM_ONE : v;
    if (!conn)
      norm_pick = 17'h0;
    else if (inv)
      norm_pick = `PIDR_NORM_ONE - lim;
    else
      norm_pick = lim;
  endfunction

  // Clamp a written time or gain value to its legal range
  function automatic logic [26:0] clamp27(input logic [31:0] v, input logic [26:0] hi);
    clamp27 = (v > {5'h0, hi}) ? hi : v[26:0];
  endfunction

  // Output saturated and the error pushes it further out
  function automatic logic windup_cond(input logic hi, input logic lo,
                                       input logic signed [17:0] e);
    windup_cond = (hi && e > 18'sh0) || (lo && e < 18'sh0);
  endfunction

  logic [`PIDR_CTRL_WIDTH-1:0] ctrl;
  logic [16:0]    manual_out;
  logic [26:0]    gain;
  logic [26:0]    ti_ms;
  logic [26:0]    td_ms;
  logic [13:0]    period_ms;
  logic [17:0]    ms_cnt;
  logic [13:0]    period_cnt;
  logic           cycle_tick;
  logic [16:0]    sp_n;
  logic [16:0]    pv_n;
  logic [16:0]    rs_n;
  logic           reset_active;
  logic           manual_on;
  pidr_state_type state;
  logic signed [17:0] err;
  logic signed [17:0] pv_now;
  logic signed [17:0] pv_prev;
  logic signed [63:0] integ;
  logic signed [63:0] iterm;
  logic signed [63:0] dterm;
  logic [16:0]    reg_out;
  logic           windup;
  logic           div_start;
  logic [63:0]    div_dividend;
  logic [31:0]    div_divisor;
  logic           div_busy;
  logic           div_done;
  logic [63:0]    div_quot;
  logic signed [63:0] sum_raw;
  logic signed [63:0] sum_sat;
  logic signed [63:0] y_raw;
  logic           sat_hi;
  logic           sat_lo;
  logic signed [63:0] int_step;
  logic           apb_wr;
  logic           apb_setup;
  logic           addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in setup phase
  assign pready    = 1'b1;
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign addr_ok   = (paddr <= `PIDR_STATUS_OFS) && (paddr[1:0] == 2'b00);

  // Configuration writes; out-of-range values clamp to the limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= `PIDR_CTRL_RST;
      manual_out <= `PIDR_MANUAL_RST;
      gain       <= `PIDR_GAIN_RST;
      ti_ms      <= `PIDR_TI_RST;
      td_ms      <= `PIDR_TD_RST;
      period_ms  <= `PIDR_PERIOD_RST;
    end else if (apb_wr) begin
      unique case (paddr)
        `PIDR_CTRL_OFS:   ctrl <= pwdata[`PIDR_CTRL_WIDTH-1:0];
        `PIDR_MANUAL_OFS: manual_out <= (pwdata > {15'h0, `PIDR_NORM_ONE})
                                        ? `PIDR_NORM_ONE : pwdata[16:0];
        `PIDR_GAIN_OFS:   gain  <= clamp27(pwdata, `PIDR_GAIN_MAX);
        `PIDR_TI_OFS:     ti_ms <= clamp27(pwdata, `PIDR_TIME_MAX);
        `PIDR_TD_OFS:     td_ms <= clamp27(pwdata, `PIDR_TIME_MAX);
        `PIDR_PERIOD_OFS: begin
          if (pwdata < {18'h0, `PIDR_PERIOD_MIN})
            period_ms <= `PIDR_PERIOD_MIN;
          else if (pwdata > {18'h0, `PIDR_PERIOD_MAX})
            period_ms <= `PIDR_PERIOD_MAX;
          else
            period_ms <= pwdata[13:0];
        end
        default: ;
      endcase
    end
  end

  // Read mux and error flag, registered so data is stable in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !addr_ok;
      prdata  <= 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          `PIDR_CTRL_OFS:   prdata <= {25'h0, ctrl};
          `PIDR_MANUAL_OFS: prdata <= {15'h0, manual_out};
          `PIDR_GAIN_OFS:   prdata <= {5'h0, gain};
          `PIDR_TI_OFS:     prdata <= {5'h0, ti_ms};
          `PIDR_TD_OFS:     prdata <= {5'h0, td_ms};
          `PIDR_PERIOD_OFS: prdata <= {18'h0, period_ms};
          `PIDR_OUTPUT_OFS: prdata <= {15'h0, norm_output_value};
          `PIDR_STATUS_OFS: prdata <= {29'h0, (state != PIDR_IDLE), reset_active, windup};
          default:          prdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  assign sp_n = norm_pick(norm_in.norm_setpoint_value, ctrl[`PIDR_CTRL_CONN_SP],
                          ctrl[`PIDR_CTRL_INV_SP]);
  assign pv_n = norm_pick(norm_in.norm_process_value, ctrl[`PIDR_CTRL_CONN_PV],
                          ctrl[`PIDR_CTRL_INV_PV]);
  assign rs_n = norm_pick(norm_in.norm_reset_value, ctrl[`PIDR_CTRL_CONN_RS],
                          ctrl[`PIDR_CTRL_INV_RS]);
  assign reset_active = (rs_n >= `PIDR_NORM_HALF);
  assign manual_on    = ctrl[`PIDR_CTRL_MANUAL];

  ////////////////////////////////////////////////////////////////////////////
  // Control-cycle timer: millisecond prescaler, then period in milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt     <= 18'h0;
      period_cnt <= 14'h0;
      cycle_tick <= 1'b0;
    end else begin
      cycle_tick <= 1'b0;
      if (ms_cnt == 18'(CYC_PER_MS - 1)) begin
        ms_cnt <= 18'h0;
        if (period_cnt >= period_ms - 14'h1) begin
          period_cnt <= 14'h0;
          cycle_tick <= 1'b1;
        end else begin
          period_cnt <= period_cnt + 14'h1;
        end
      end else begin
        ms_cnt <= ms_cnt + 18'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider shared by the integral and derivative terms to save area
  pidr_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (div_start),
    .dividend (div_dividend),
    .divisor  (div_divisor),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

  // Divider operands by phase; zero integral time disables the integral term
  always_comb begin
    div_start    = 1'b0;
    div_dividend = 64'h0;
    div_divisor  = 32'h1;
    if (state == PIDR_IDLE) begin
      div_start    = cycle_tick && !manual_on && !reset_active;
      div_dividend = (ti_ms == 27'h0) ? 64'h0 : integ;
      div_divisor  = (ti_ms == 27'h0) ? 32'h1 : {5'h0, ti_ms};
    end else if (state == PIDR_DIV_INT) begin
      div_start    = div_done;
      // Derivative from process variable change, not error change
      div_dividend = 64'($signed({1'b0, td_ms}) * (pv_now - pv_prev));
      div_divisor  = {18'h0, period_ms};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator sum, gain and saturation flags
  always_comb begin
    sum_raw = 64'(err) + iterm - dterm;
    if (sum_raw > `PIDR_SUM_MAX)
      sum_sat = `PIDR_SUM_MAX;
    else if (sum_raw < `PIDR_SUM_MIN)
      sum_sat = `PIDR_SUM_MIN;
    else
      sum_sat = sum_raw;
    y_raw    = (sum_sat * $signed({37'h0, gain})) >>> `PIDR_GAIN_FRAC;
    sat_hi   = y_raw > $signed({47'h0, `PIDR_NORM_ONE});
    sat_lo   = y_raw < 64'sh0;
    int_step = 64'($signed(err) * $signed({1'b0, period_ms}));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update sequence: capture, two divisions, apply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= PIDR_IDLE;
      err     <= 18'sh0;
      pv_now  <= 18'sh0;
      pv_prev <= 18'sh0;
      iterm   <= 64'sh0;
      dterm   <= 64'sh0;
      reg_out <= 17'h0;
      windup  <= 1'b0;
    end else begin
      unique case (state)
        PIDR_IDLE: begin
          if (cycle_tick) begin
            pv_now <= $signed({1'b0, pv_n});
            err    <= $signed({1'b0, sp_n}) - $signed({1'b0, pv_n});
            if (manual_on || reset_active)
              pv_prev <= $signed({1'b0, pv_n});  // No derivative kick on resume
            else
              state <= PIDR_DIV_INT;
          end
        end
        PIDR_DIV_INT: begin
          if (div_done) begin
            iterm <= $signed(div_quot);
            state <= PIDR_DIV_DER;
          end
        end
        PIDR_DIV_DER: begin
          if (div_done) begin
            dterm <= $signed(div_quot);
            state <= PIDR_APPLY;
          end
        end
        PIDR_APPLY: begin
          // Clip to 0..1
          if (sat_lo)
            reg_out <= 17'h0;
          else if (sat_hi)
            reg_out <= `PIDR_NORM_ONE;
          else
            reg_out <= y_raw[16:0];
          windup  <= windup_cond(sat_hi, sat_lo, err);
          pv_prev <= pv_now;
          state   <= PIDR_IDLE;
        end
      endcase
      // Initial state: no stale result shows once the reset input drops
      if (reset_active)
        reg_out <= 17'h0;
    end
  end

  // Integral accumulator: held between cycles, frozen on windup, cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ <= 64'sh0;
    end else if (reset_active) begin
      integ <= 64'sh0;
    end else if (state == PIDR_APPLY && !windup_cond(sat_hi, sat_lo, err)) begin
      integ <= integ + int_step;
    end
  end

  // Output select; reset input outranks manual mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      norm_output_value <= 17'h0;
    else if (reset_active)
      norm_output_value <= 17'h0;
    else if (manual_on)
      norm_output_value <= manual_out;
    else
      norm_output_value <= reg_out;
  end
endmodule // pidr_regulator
`default_nettype wire

// ### tb/pidr_checker.sv
// Port assertions for the PID regulator
`include "pidr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module pidr_checker #(
  parameter int unsigned CYC_PER_MS = `PIDR_CYC_PER_MS
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic                      pready,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  input wire pidr_pkg::pidr_inputs_type norm_in,
  input wire logic [16:0]               norm_output_value
);
  import pidr_pkg::*;
  logic [6:0]  ctrl_sh;
  logic [16:0] man_sh;
  logic [16:0] rs_lim;
  logic [16:0] rs_eff;
  logic        rs_act;
  logic        wr;
  logic        bad_adr;
  //////////////////////////////////////////////////////////////////////
  // Shadow of the mode registers; the checker cannot see inside
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh <= `PIDR_CTRL_RST;
      man_sh  <= `PIDR_MANUAL_RST;
    end else if (wr && paddr == `PIDR_CTRL_OFS) begin
      ctrl_sh <= pwdata[6:0];
    end else if (wr && paddr == `PIDR_MANUAL_OFS) begin
      man_sh <= (pwdata > 32'h10000) ? `PIDR_NORM_ONE : pwdata[16:0];
    end
  end
  // Effective reset level after limit, inversion and connection
  assign rs_lim = (norm_in.norm_reset_value > `PIDR_NORM_ONE) ? `PIDR_NORM_ONE
                                                              : norm_in.norm_reset_value;
  assign rs_eff = ctrl_sh[2] ? (`PIDR_NORM_ONE - rs_lim) : rs_lim;
  assign rs_act = ctrl_sh[6] && (rs_eff >= `PIDR_NORM_HALF);
  assign bad_adr = (paddr > 12'h01c) || (paddr[1:0] != 2'h0);
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence man_mode_s;
    ctrl_sh[3] && !rs_act;
  endsequence
  sequence setup_s;
    psel && !penable && !pwrite;
  endsequence
  clip_range_a: assert property (norm_output_value <= `PIDR_NORM_ONE)
    else $error("output above one");
  reset_zero_a: assert property (rs_act |=> norm_output_value == 17'h0)
    else $error("output not zero under reset input");
  reset_inv_a: assert property (ctrl_sh[6] && ctrl_sh[2]
    && norm_in.norm_reset_value == 17'h0 |=> norm_output_value == 17'h0)
    else $error("inverted reset ignored");
  manual_out_a: assert property (man_mode_s |=> norm_output_value == $past(man_sh))
    else $error("manual output wrong");
  manual_hold_a: assert property (man_mode_s [*2] ##0 $stable(man_sh)
    |=> $stable(norm_output_value)) else $error("manual output moved");
  unmapped_err_a: assert property (setup_s ##0 bad_adr ##1 penable
    |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  mapped_ok_a: assert property ((setup_s ##0 !bad_adr) ##1 penable |-> !pslverr)
    else $error("mapped read refused");
  gain_clamp_a: assert property (psel && penable && !pwrite && paddr == `PIDR_GAIN_OFS
    |-> prdata <= {5'h0, `PIDR_GAIN_MAX}) else $error("gain above limit");
  period_range_a: assert property (psel && penable && !pwrite && paddr == `PIDR_PERIOD_OFS
    |-> prdata >= 32'h1 && prdata <= 32'h2710) else $error("period out of range");
endmodule // pidr_checker
bind pidr_regulator pidr_checker #(.CYC_PER_MS(CYC_PER_MS)) u_pidr_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .norm_in(norm_in), .norm_output_value(norm_output_value));
`default_nettype wire

// ### tb/pidr_source.sv
// Upstream function-block model driving the normalized inputs
`timescale 1ns/100ps
`default_nettype none
module pidr_source (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      slow,
  input  wire pidr_pkg::pidr_inputs_type target,
  output var  pidr_pkg::pidr_inputs_type norm_in
);
  import pidr_pkg::*;
  // A slow source slews like a filtered block; prompt ones jump
  function automatic logic [16:0] step(input logic [16:0] cur, input logic [16:0] tgt);
    if (!slow) return tgt;
    if (tgt > cur + 17'h100) return cur + 17'h100;
    if (cur > tgt + 17'h100) return cur - 17'h100;
    return tgt;
  endfunction
  // Any logical output may feed any input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      norm_in <= '0;
    end else begin
      norm_in.norm_setpoint_value <= step(norm_in.norm_setpoint_value,
                                          target.norm_setpoint_value);
      norm_in.norm_process_value  <= step(norm_in.norm_process_value, target.norm_process_value);
      norm_in.norm_reset_value    <= step(norm_in.norm_reset_value, target.norm_reset_value);
    end
  end
endmodule // pidr_source
`default_nettype wire

// ### tb/tb_pidr_regulator.sv
// Self-checking bench for the PID regulator
`include "pidr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_pidr_regulator;
  import pidr_pkg::*;
  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic            slow;
  logic            pready;
  logic            pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic [16:0]     norm_output_value;
  logic [16:0]     mval;
  pidr_inputs_type norm_in;
  pidr_inputs_type target;
  logic [32:0]     exp_q[$];
  string           name_q[$];
  int              bad_count = 0;
  int              n_tests = 0;
  int              cyc = 0;
  int              seed;
  pidr_regulator #(.CYC_PER_MS(10)) u_pidr_regulator (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .norm_in(norm_in),
    .norm_output_value(norm_output_value));
  pidr_source u_pidr_source (.pclk(pclk), .presetn(presetn), .slow(slow), .target(target),
    .norm_in(norm_in));
  //////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A hang ends as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] ex);
    n_tests++;
    if (seen !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, ex, seen);
    end
  endtask
  // Read answers are judged against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) check("unexpected read", 33'h0, 33'h1);
      else check(name_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic cycles(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    name_q.push_back(what);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic out_is(input string what, input logic [16:0] ex);
    check(what, {16'h0, norm_output_value}, {16'h0, ex});
  endtask
  task automatic reg_case(input logic [31:0] g, c, input logic [16:0] sp, pv, ex);
    apb(1'b1, `PIDR_GAIN_OFS, g);
    apb(1'b1, `PIDR_CTRL_OFS, c);
    target <= {sp, pv, 17'h0};
    cycles(500);
    out_is("regulated out", ex);
  endtask
  task automatic wait_change(input int lim);
    logic [16:0] old;
    old = norm_output_value;
    for (int i = 0; i < lim && norm_output_value === old; i++) @(posedge pclk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 81741;
    {psel, penable, pwrite, slow, paddr, pwdata} = '0;
    target  = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd("ctrl", `PIDR_CTRL_OFS, 33'h0);
    rd("manual", `PIDR_MANUAL_OFS, 33'h8000);
    rd("gain", `PIDR_GAIN_OFS, 33'h400);
    rd("ti", `PIDR_TI_OFS, 33'h64);
    rd("td", `PIDR_TD_OFS, 33'ha);
    rd("period", `PIDR_PERIOD_OFS, 33'h1);
    rd("unmapped", 12'h020, 33'h1_0000_0000);
    $display("Test reset values done");
    // Settings beyond their range are clamped
    apb(1'b1, `PIDR_GAIN_OFS, 32'hffffffff);
    rd("gain max", `PIDR_GAIN_OFS, {6'h0, `PIDR_GAIN_MAX});
    apb(1'b1, `PIDR_TI_OFS, 32'hffffffff);
    rd("ti max", `PIDR_TI_OFS, {6'h0, `PIDR_TIME_MAX});
    apb(1'b1, `PIDR_PERIOD_OFS, 32'h0);
    rd("period min", `PIDR_PERIOD_OFS, 33'h1);
    apb(1'b1, `PIDR_PERIOD_OFS, 32'h4e20);
    rd("period max", `PIDR_PERIOD_OFS, 33'h2710);
    apb(1'b1, `PIDR_MANUAL_OFS, 32'h20000);
    rd("manual max", `PIDR_MANUAL_OFS, 33'h10000);
    apb(1'b1, `PIDR_PERIOD_OFS, 32'h1);
    apb(1'b1, `PIDR_TI_OFS, 32'h0);
    apb(1'b1, `PIDR_TD_OFS, 32'h0);
    $display("Test clamping done");
    // Manual mode with random levels, then the reset input against it
    for (int i = 0; i < 3; i++) begin
      mval = 17'($unsigned($random(seed)) % 32'h10001);
      apb(1'b1, `PIDR_MANUAL_OFS, {15'h0, mval});
      apb(1'b1, `PIDR_CTRL_OFS, 32'h8);
      cycles(3);
      out_is("manual out", mval);
    end
    apb(1'b1, `PIDR_CTRL_OFS, 32'h48);
    target <= {34'h0, 17'h08000};
    cycles(3);
    out_is("reset at half", 17'h0);
    target <= {34'h0, 17'h07fff};
    cycles(3);
    out_is("reset below half", mval);
    apb(1'b1, `PIDR_CTRL_OFS, 32'h4c);
    cycles(3);
    out_is("inverted reset", 17'h0);
    target <= {34'h0, 17'h0};
    cycles(3);
    out_is("inverted zero reset", 17'h0);
    apb(1'b1, `PIDR_CTRL_OFS, 32'h8);
    target <= {34'h0, 17'h10000};
    cycles(3);
    out_is("reset unconnected", mval);
    $display("Test manual and reset done");
    // Proportional path, clipping, inversion, unconnected setpoint
    reg_case(32'h400, 32'h30, 17'h6000, 17'h2000, 17'h4000);
    reg_case(32'h400, 32'h30, 17'h2000, 17'h6000, 17'h0);
    reg_case(32'h1000, 32'h30, 17'h8000, 17'h0, 17'h10000);
    reg_case(32'h400, 32'h32, 17'h6000, 17'he000, 17'h4000);
    reg_case(32'h400, 32'h20, 17'h8000, 17'h0, 17'h0);
    // Derivative follows the process variable only
    apb(1'b1, `PIDR_TD_OFS, 32'h1);
    reg_case(32'h400, 32'h30, 17'h3000, 17'h1000, 17'h2000);
    target <= {17'h5000, 17'h1000, 17'h0};
    wait_change(400);
    out_is("setpoint step", 17'h4000);
    target <= {17'h5000, 17'h2000, 17'h0};
    wait_change(400);
    out_is("feedback step", 17'h2000);
    $display("Test regulation done");
    // Integral saturates, windup stops it, reset input clears it
    apb(1'b1, `PIDR_TD_OFS, 32'h0);
    apb(1'b1, `PIDR_TI_OFS, 32'h1);
    apb(1'b1, `PIDR_CTRL_OFS, 32'h70);
    // Clear what earlier cases left in the integrator; outlast an update
    target <= {17'h2000, 17'h1000, 17'h10000};
    cycles(150);
    out_is("integral reset", 17'h0);
    slow   <= 1'b1;
    target <= {17'h2000, 17'h1000, 17'h0};
    cycles(5000);
    out_is("integral saturated", 17'h10000);
    rd("output reg", `PIDR_OUTPUT_OFS, 33'h10000);
    target <= {17'h1000, 17'h2000, 17'h0};
    for (int i = 0; i < 600 && norm_output_value === 17'h10000; i++) @(posedge pclk);
    #1;
    check("windup release", norm_output_value < 17'h10000, 33'h1);
    target <= {17'h1000, 17'h2000, 17'h10000};
    cycles(300);
    out_is("reset clears", 17'h0);
    target <= {17'h1000, 17'h1000, 17'h0};
    cycles(600);
    out_is("integral cleared", 17'h0);
    $display("Test integral done");
    test_done();
  end
endmodule // tb_pidr_regulator
`default_nettype wire
